// [core/tcc_conv_ctrl.sv]
`timescale 1ns/1ns
module tcc_conv_ctrl #(
	parameter longint unsigned CLK_HZ = 100000000
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// i2c pins, open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_sel_pin,
	// aux pin and host triggers
	input wire logic aux_pin,
	input wire logic host_conv_req,
	input wire logic irq_clear,
	// converter side
	output logic bias_en,
	output logic adc_start,
	input wire logic adc_done,
	input wire logic [11:0] adc_data,
	input wire logic pen_detected,
	// results and configuration
	output logic irq_out_n,
	output logic [15:0] chan_word,
	output logic data_invalid,
	output logic result_valid,
	output logic [7:0] pen_res_kohm,
	output logic [2:0] filter_order_sel_samples,
	output logic filter_order_sel_median
);
	import tcc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: scl, sda, aux, address select
	logic [3:0] pin_s1_reg;
	logic [3:0] pin_s2_reg;
	logic [3:0] pin_s3_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			pin_s1_reg <= 4'hF;
			pin_s2_reg <= 4'hF;
			pin_s3_reg <= 4'hF;
		end else begin
			pin_s1_reg <= {addr_sel_pin, aux_pin, sda_in, scl_in};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	logic scl_rise, scl_fall, sda_lvl, start_det, stop_det, aux_rise, aux_fall;
	assign scl_rise = pin_s2_reg[0] && !pin_s3_reg[0];
	assign scl_fall = !pin_s2_reg[0] && pin_s3_reg[0];
	assign sda_lvl = pin_s2_reg[1];
	assign start_det = pin_s2_reg[0] && pin_s3_reg[0] && !pin_s2_reg[1] && pin_s3_reg[1];
	assign stop_det = pin_s2_reg[0] && pin_s3_reg[0] && pin_s2_reg[1] && !pin_s3_reg[1];
	assign aux_rise = pin_s2_reg[2] && !pin_s3_reg[2];
	assign aux_fall = !pin_s2_reg[2] && pin_s3_reg[2];

	////////////////////////////////////////////////////////////////////////
	// control registers
	logic [7:0] rate_and_settle_control_reg;
	logic [7:0] aux_irq_filter_control_reg;
	logic [3:0] rate_code, settle_code;
	tcc_aux_t aux_acquire_trigger;
	logic pen_qualified_irq_en;
	logic [1:0] pen_detect_res_sel, filter_order_sel;

	assign rate_code = rate_and_settle_control_reg[TCC_RATE_LSB +: 4];
	assign settle_code = rate_and_settle_control_reg[TCC_SETTLE_LSB +: 4];
	assign aux_acquire_trigger = tcc_aux_t'(aux_irq_filter_control_reg[TCC_AUX_LSB +: 2]);
	assign pen_qualified_irq_en = aux_irq_filter_control_reg[TCC_PEN_QUALIFIED_IRQ_EN_BIT];
	assign pen_detect_res_sel = aux_irq_filter_control_reg[TCC_PDRES_LSB +: 2];
	assign filter_order_sel = aux_irq_filter_control_reg[TCC_FILTER_ORDER_SEL_LSB +: 2];

	function automatic logic [7:0] reg_read(input logic [4:0] ra,
		input logic [7:0] c0, input logic [7:0] c1);
		if (ra == TCC_RA_RATE_SETTLE) begin
			return c0;
		end else if (ra == TCC_RA_AUX_IRQ_FILTER_ORDER_SEL) begin
			return c1;
		end else begin
			return TCC_READ_UNMAPPED;
		end
	endfunction : reg_read

	////////////////////////////////////////////////////////////////////////
	// i2c slave
	typedef enum {IS_IDLE, IS_ADDR, IS_CMD, IS_WDATA, IS_SKIP, IS_RDATA} tcc_i2c_state_t;
	tcc_i2c_state_t i2c_st_reg, i2c_nxt_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic ack_slot_reg;
	logic [4:0] ptr_reg;
	logic byte_end, wr_stb;
	logic [7:0] rd_byte;

	assign byte_end = scl_fall && !ack_slot_reg && bit_cnt_reg == 4'h8;
	assign wr_stb = byte_end && i2c_st_reg == IS_WDATA;
	assign rd_byte = reg_read(ptr_reg, rate_and_settle_control_reg, aux_irq_filter_control_reg);
	assign sda_out = 1'b0;

	always_ff @(posedge clk) begin
		if (srst || stop_det) begin
			i2c_st_reg <= IS_IDLE;
			i2c_nxt_reg <= IS_IDLE;
			bit_cnt_reg <= 4'h0;
			ack_slot_reg <= 1'b0;
			sda_oe <= 1'b0;
			if (srst) begin
				shift_reg <= 8'h00;
				tx_reg <= 8'h00;
				ptr_reg <= 5'h00;
			end
		end else if (start_det) begin
			i2c_st_reg <= IS_ADDR;
			bit_cnt_reg <= 4'h0;
			ack_slot_reg <= 1'b0;
			sda_oe <= 1'b0;
		end else if (i2c_st_reg == IS_RDATA) begin
			if (scl_rise && ack_slot_reg && sda_lvl) begin
				i2c_st_reg <= IS_IDLE;
			end else if (scl_fall && ack_slot_reg) begin
				ack_slot_reg <= 1'b0;
				tx_reg <= {rd_byte[6:0], 1'b0};
				sda_oe <= !rd_byte[7];
				ptr_reg <= ptr_reg + 5'h01;
				bit_cnt_reg <= 4'h1;
			end else if (scl_fall && bit_cnt_reg == 4'h8) begin
				// release for the master's acknowledge
				ack_slot_reg <= 1'b1;
				sda_oe <= 1'b0;
			end else if (scl_fall) begin
				tx_reg <= {tx_reg[6:0], 1'b0};
				sda_oe <= !tx_reg[7];
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end else if (i2c_st_reg != IS_IDLE) begin
			if (scl_rise && !ack_slot_reg) begin
				shift_reg <= {shift_reg[6:0], sda_lvl};
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end else if (byte_end) begin
				bit_cnt_reg <= 4'h0;
				ack_slot_reg <= 1'b1;
				sda_oe <= 1'b1;
				i2c_nxt_reg <= IS_SKIP;
				case (i2c_st_reg)
					IS_ADDR: begin
						if (shift_reg[7:1] != {TCC_SLAVE_ADDR_HI, pin_s2_reg[3]}) begin
							i2c_st_reg <= IS_IDLE;
							sda_oe <= 1'b0;
						end else if (shift_reg[0]) begin
							i2c_nxt_reg <= IS_RDATA;
						end else begin
							i2c_nxt_reg <= IS_CMD;
						end
					end
					IS_CMD: begin
						ptr_reg <= shift_reg[TCC_RA_W-1:0];
						if (shift_reg[7:5] == TCC_CMD_WRITE) begin
							i2c_nxt_reg <= IS_WDATA;
						end
					end
					IS_WDATA: begin
						ptr_reg <= ptr_reg + 5'h01;
						i2c_nxt_reg <= IS_WDATA;
					end
					default: begin
						i2c_nxt_reg <= IS_SKIP;
					end
				endcase
			end else if (scl_fall && ack_slot_reg) begin
				ack_slot_reg <= 1'b0;
				i2c_st_reg <= i2c_nxt_reg;
				if (i2c_nxt_reg == IS_RDATA) begin
					tx_reg <= {rd_byte[6:0], 1'b0};
					sda_oe <= !rd_byte[7];
					ptr_reg <= ptr_reg + 5'h01;
					bit_cnt_reg <= 4'h1;
				end else begin
					sda_oe <= 1'b0;
				end
			end
		end
	end

	// readback holds the written value; reserved bit stays zero
	always_ff @(posedge clk) begin
		if (srst) begin
			rate_and_settle_control_reg <= TCC_RST_RATE_SETTLE;
			aux_irq_filter_control_reg <= TCC_RST_AUX_IRQ_FILTER_ORDER_SEL;
		end else if (wr_stb && ptr_reg == TCC_RA_RATE_SETTLE) begin
			rate_and_settle_control_reg <= shift_reg;
		end else if (wr_stb && ptr_reg == TCC_RA_AUX_IRQ_FILTER_ORDER_SEL) begin
			aux_irq_filter_control_reg <= shift_reg & TCC_WMASK_AUX_IRQ_FILTER_ORDER_SEL;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// conversion triggers
	logic [TCC_CNT_W-1:0] rate_cnt_reg;
	logic [3:0] rate_prev_reg;
	logic rate_tick, aux_hit, conv_trig;

	assign rate_tick = rate_code != TCC_RATE_MANUAL && rate_cnt_reg == '0;

	// reload on every tick and whenever the code changes, so a new rate acts at once
	always_ff @(posedge clk) begin
		if (srst) begin
			rate_cnt_reg <= '0;
			rate_prev_reg <= TCC_RATE_MANUAL;
		end else begin
			rate_prev_reg <= rate_code;
			if (rate_code == TCC_RATE_MANUAL) begin
				rate_cnt_reg <= '0;
			end else if (rate_tick || rate_code != rate_prev_reg) begin
				rate_cnt_reg <= tcc_rate_cycles(rate_code, CLK_HZ) - 1'b1;
			end else begin
				rate_cnt_reg <= rate_cnt_reg - 1'b1;
			end
		end
	end

	always_comb begin
		case (aux_acquire_trigger)
			TCC_AUX_RISE: aux_hit = aux_rise;
			TCC_AUX_FALL: aux_hit = aux_fall;
			TCC_AUX_BOTH: aux_hit = aux_rise || aux_fall;
			default: aux_hit = 1'b0;
		endcase
	end

	// aux edges are honoured in manual mode only, as the host is expected to arrange
	assign conv_trig = (rate_code == TCC_RATE_MANUAL) ? (host_conv_req || aux_hit)
		: rate_tick;

	////////////////////////////////////////////////////////////////////////
	// conversion sequence: settle, convert, repeat per filter sample
	typedef enum {CS_IDLE, CS_SETTLE, CS_CONVERT, CS_DONE} tcc_conv_state_t;
	tcc_conv_state_t cs_reg;
	logic [2:0] sample_cnt_reg;
	logic pen_ok_reg;
	logic [11:0] last_data_reg;
	logic settle_load, settle_done;

	assign settle_load = (cs_reg == CS_IDLE && conv_trig) ||
		(cs_reg == CS_CONVERT && adc_done && sample_cnt_reg + 3'h1 != filter_order_sel_samples);

	tcc_delay_timer tcc_delay_timer_inst (
		.clk(clk),
		.srst(srst),
		.load(settle_load),
		.load_val(tcc_settle_cycles(settle_code, CLK_HZ)),
		.done(settle_done)
	);

	always_ff @(posedge clk) begin
		if (srst) begin
			cs_reg <= CS_IDLE;
			sample_cnt_reg <= 3'h0;
			pen_ok_reg <= 1'b0;
			last_data_reg <= 12'h000;
			adc_start <= 1'b0;
		end else begin
			adc_start <= 1'b0;
			case (cs_reg)
				CS_IDLE: begin
					if (conv_trig) begin
						cs_reg <= CS_SETTLE;
						sample_cnt_reg <= 3'h0;
						pen_ok_reg <= 1'b1;
					end
				end
				CS_SETTLE: begin
					if (settle_done) begin
						adc_start <= 1'b1;
						cs_reg <= CS_CONVERT;
					end
				end
				CS_CONVERT: begin
					if (adc_done) begin
						pen_ok_reg <= pen_ok_reg && pen_detected;
						last_data_reg <= adc_data;
						sample_cnt_reg <= sample_cnt_reg + 3'h1;
						cs_reg <= (sample_cnt_reg + 3'h1 == filter_order_sel_samples) ? CS_DONE : CS_SETTLE;
					end
				end
				default: begin
					cs_reg <= CS_IDLE;
				end
			endcase
		end
	end

	assign bias_en = cs_reg == CS_SETTLE || cs_reg == CS_CONVERT;

	////////////////////////////////////////////////////////////////////////
	// results and interrupt
	logic irq_pend_reg;
	logic irq_set;

	assign irq_set = cs_reg == CS_DONE && (!pen_qualified_irq_en || pen_ok_reg);
	assign irq_out_n = !irq_pend_reg;

	// a new end of conversion wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_pend_reg <= 1'b0;
		end else if (irq_set) begin
			irq_pend_reg <= 1'b1;
		end else if (irq_clear) begin
			irq_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			chan_word <= TCC_INVALID_WORD;
			data_invalid <= 1'b1;
			result_valid <= 1'b0;
		end else begin
			result_valid <= cs_reg == CS_DONE;
			if (cs_reg == CS_DONE) begin
				data_invalid <= !pen_ok_reg;
				chan_word <= pen_ok_reg ? {4'h0, last_data_reg} : TCC_INVALID_WORD;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pen_res_kohm <= TCC_PEN_RES_KOHM[0];
			filter_order_sel_samples <= TCC_FILTER_ORDER_SEL_SAMPLES[0];
			filter_order_sel_median <= 1'b0;
		end else begin
			pen_res_kohm <= TCC_PEN_RES_KOHM[pen_detect_res_sel];
			filter_order_sel_samples <= TCC_FILTER_ORDER_SEL_SAMPLES[filter_order_sel];
			filter_order_sel_median <= filter_order_sel == TCC_FILTER_ORDER_SEL_MEDIAN;
		end
	end

endmodule : tcc_conv_ctrl

// [core/tcc_delay_timer.sv]
`timescale 1ns/1ns
module tcc_delay_timer (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control
	input wire logic load,
	input wire logic [tcc_pkg::TCC_CNT_W-1:0] load_val,
	// status
	output logic done
);
	import tcc_pkg::*;

	logic [TCC_CNT_W-1:0] cnt_reg;

	// done fires load_val cycles after the load
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_reg <= '0;
		end else if (load) begin
			cnt_reg <= load_val;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || load) begin
			done <= 1'b0;
		end else begin
			done <= (cnt_reg == {{(TCC_CNT_W-1){1'b0}}, 1'b1});
		end
	end

endmodule : tcc_delay_timer

// [core/tcc_pkg.sv]
package tcc_pkg;

	localparam int unsigned TCC_CNT_W = 32;
	localparam int unsigned TCC_RA_W = 5;

	// i2c register addresses and command byte prefixes
	localparam logic [4:0] TCC_RA_RATE_SETTLE = 5'h00;
	localparam logic [4:0] TCC_RA_AUX_IRQ_FILTER_ORDER_SEL = 5'h01;
	localparam logic [2:0] TCC_CMD_WRITE = 3'h0;
	localparam logic [2:0] TCC_CMD_READ_ADDR = 3'h2;
	localparam logic [5:0] TCC_SLAVE_ADDR_HI = 6'h24;

	// reset values and write masks
	localparam logic [7:0] TCC_RST_RATE_SETTLE = 8'h00;
	localparam logic [7:0] TCC_RST_AUX_IRQ_FILTER_ORDER_SEL = 8'h20;
	localparam logic [7:0] TCC_WMASK_AUX_IRQ_FILTER_ORDER_SEL = 8'hEF;
	localparam logic [7:0] TCC_READ_UNMAPPED = 8'h00;

	// field positions
	localparam int unsigned TCC_RATE_LSB = 4;
	localparam int unsigned TCC_SETTLE_LSB = 0;
	localparam int unsigned TCC_AUX_LSB = 6;
	localparam int unsigned TCC_PEN_QUALIFIED_IRQ_EN_BIT = 5;
	localparam int unsigned TCC_PDRES_LSB = 2;
	localparam int unsigned TCC_FILTER_ORDER_SEL_LSB = 0;

	typedef enum logic [1:0] {
		TCC_AUX_ANALOG = 2'h0,
		TCC_AUX_RISE = 2'h1,
		TCC_AUX_FALL = 2'h2,
		TCC_AUX_BOTH = 2'h3
	} tcc_aux_t;

	localparam logic [3:0] TCC_RATE_MANUAL = 4'h0;
	localparam logic [1:0] TCC_FILTER_ORDER_SEL_MEDIAN = 2'h3;
	localparam logic [15:0] TCC_INVALID_WORD = 16'hFFFF;
	localparam longint unsigned TCC_NS_PER_S = 64'd1000000000;

	// settle times in ns, nominal
	localparam longint unsigned TCC_SETTLE_NS [16] = '{
		500, 1100, 2200, 4400, 8900, 17800, 35500, 71000,
		140000, 280000, 570000, 1140000, 2270000, 4550000, 9090000, 18190000};
	// conversion rates in coordinates per second, code 0 is manual
	localparam longint unsigned TCC_RATE_CPS [16] = '{
		0, 10, 20, 40, 60, 80, 100, 200,
		300, 400, 500, 1000, 2000, 3000, 4000, 5000};
	localparam logic [7:0] TCC_PEN_RES_KOHM [4] = '{8'h64, 8'hC8, 8'h32, 8'h19};
	localparam logic [2:0] TCC_FILTER_ORDER_SEL_SAMPLES [4] = '{3'h1, 3'h3, 3'h5, 3'h7};

	// least time, so round up, never below one cycle
	function automatic logic [31:0] tcc_settle_cycles(input logic [3:0] code,
		input longint unsigned clk_hz);
		longint unsigned c;
		c = (TCC_SETTLE_NS[code] * clk_hz + TCC_NS_PER_S - 1) / TCC_NS_PER_S;
		if (c == 0) begin
			c = 1;
		end
		return c[31:0];
	endfunction : tcc_settle_cycles

	function automatic logic [31:0] tcc_rate_cycles(input logic [3:0] code,
		input longint unsigned clk_hz);
		longint unsigned c;
		c = 1;
		if (TCC_RATE_CPS[code] != 0) begin
			c = clk_hz / TCC_RATE_CPS[code];
		end
		if (c == 0) begin
			c = 1;
		end
		return c[31:0];
	endfunction : tcc_rate_cycles

endpackage : tcc_pkg

// [test/tcc_conv_ctrl_tb.sv]
`timescale 1ns/1ns
module tcc_conv_ctrl_tb;
	import tcc_pkg::*;
	logic clk, srst, sda_oe, sda_out, scl, sda_low, aux_pin, host_conv_req, irq_clear;
	logic bias_en, adc_start, adc_done, pen_detected, irq_out_n, data_invalid, result_valid;
	logic filter_order_sel_median;
	logic [15:0] chan_word;
	logic [7:0] pen_res_kohm, d0, d1;
	logic [2:0] filter_order_sel_samples;
	int bad_count = 0;
	int tests_run = 0;
	int n, m;
	// pulled up whenever nobody pulls low
	wire logic sda = !(sda_oe || sda_low);
	tcc_conv_ctrl #(.CLK_HZ(1000000)) tcc_conv_ctrl_inst (.clk(clk), .srst(srst),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_pin(1'b1),
		.aux_pin(aux_pin), .host_conv_req(host_conv_req), .irq_clear(irq_clear),
		.bias_en(bias_en), .adc_start(adc_start), .adc_done(adc_done), .adc_data(12'hA5C),
		.pen_detected(pen_detected), .irq_out_n(irq_out_n), .chan_word(chan_word),
		.data_invalid(data_invalid), .result_valid(result_valid), .pen_res_kohm(pen_res_kohm),
		.filter_order_sel_samples(filter_order_sel_samples), .filter_order_sel_median(filter_order_sel_median));
	tcc_host_model tcc_host_model_inst (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// converter answers one cycle after each start
	always @(negedge clk) adc_done <= adc_start;
	////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	task automatic put(input logic [7:0] b, input logic exp_n);
		logic [7:0] rb;
		logic a;
		tcc_host_model_inst.xfer(b, 1'b1, rb, a);
		check("ack", a, exp_n);
	endtask : put
	task automatic wr_reg(input logic [4:0] ra, input logic [7:0] v0, input logic [7:0] v1,
		input bit two);
		tcc_host_model_inst.start();
		// address pin is tied high at the instance
		put({TCC_SLAVE_ADDR_HI, 1'b1, 1'b0}, 1'b0);
		put({TCC_CMD_WRITE, ra}, 1'b0);
		put(v0, 1'b0);
		if (two) put(v1, 1'b0);
		tcc_host_model_inst.stop();
	endtask : wr_reg
	task automatic rd_reg(input logic [4:0] ra);
		logic a;
		tcc_host_model_inst.start();
		put({TCC_SLAVE_ADDR_HI, 1'b1, 1'b0}, 1'b0);
		put({TCC_CMD_READ_ADDR, ra}, 1'b0);
		tcc_host_model_inst.start();
		put({TCC_SLAVE_ADDR_HI, 1'b1, 1'b1}, 1'b0);
		tcc_host_model_inst.xfer(8'hFF, 1'b0, d0, a);
		tcc_host_model_inst.xfer(8'hFF, 1'b1, d1, a);
		tcc_host_model_inst.stop();
	endtask : rd_reg
	// counts cycles to the next start, gives up at 1000
	task automatic next_start(output int k);
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (!adc_start && k < 1000);
	endtask : next_start
	task automatic conv_req(input logic pen, output int k);
		pen_detected = pen;
		host_conv_req = 1'b1;
		next_start(k);
		host_conv_req = 1'b0;
		repeat (6) @(negedge clk);
	endtask : conv_req
	////////////////////////////////////////
	task automatic t_regs();
		check("word", chan_word, 16'hFFFF);
		rd_reg(5'h00);
		check("ctrl0", d0, 8'h00);
		check("ctrl1", d1, 8'h20);
		wr_reg(5'h00, 8'h03, 8'hFF, 1'b1);
		rd_reg(5'h00);
		check("ctrl0", d0, 8'h03);
		check("ctrl1", d1, 8'hEF);
		check("median", filter_order_sel_median, 1'b1);
		rd_reg(5'h01);
		check("unmapped", d1, 8'h00);
		tcc_host_model_inst.start();
		put(8'h50, 1'b1);
		tcc_host_model_inst.stop();
	endtask : t_regs
	task automatic t_decode();
		logic [7:0] kohm [4] = '{8'h64, 8'hC8, 8'h32, 8'h19};
		logic [2:0] smp [4] = '{3'h1, 3'h3, 3'h5, 3'h7};
		for (int i = 0; i < 4; i++) begin
			wr_reg(5'h01, {4'h2, i[1:0], i[1:0]}, 8'h00, 1'b0);
			check("kohm", pen_res_kohm, kohm[i]);
			check("samples", filter_order_sel_samples, smp[i]);
		end
	endtask : t_decode
	task automatic t_conv();
		wr_reg(5'h00, 8'h00, 8'h20, 1'b1);
		conv_req(1'b0, n);
		check("irq no pen", irq_out_n, 1'b1);
		conv_req(1'b1, n);
		check("irq pen", irq_out_n, 1'b0);
		check("word", chan_word, 16'h0A5C);
		irq_clear = 1'b1;
		@(negedge clk);
		irq_clear = 1'b0;
		check("irq cleared", irq_out_n, 1'b1);
		wr_reg(5'h01, 8'h00, 8'h00, 1'b0);
		conv_req(1'b0, n);
		check("irq always", irq_out_n, 1'b0);
		check("invalid", data_invalid, 1'b1);
		check("word", chan_word, 16'hFFFF);
		// settle codes 0 and 8 are 1 and 140 cycles at the 1 MHz sim clock
		wr_reg(5'h00, 8'h08, 8'h00, 1'b0);
		conv_req(1'b0, m);
		check("settle", 16'(m - n), 16'd139);
	endtask : t_conv
	// every filter sample gets its own settle and start, then the set ends
	task automatic t_filter();
		for (int j = 1; j < 4; j++) begin
			wr_reg(5'h00, 8'h00, {6'h00, j[1:0]}, 1'b1);
			pen_detected = 1'b1;
			host_conv_req = 1'b1;
			next_start(n);
			host_conv_req = 1'b0;
			for (int s = 1; s < 2 * j + 1; s++) begin
				next_start(n);
				check("sample gap", n, 16'h0003);
			end
			next_start(n);
			check("set end", n, 16'h03E8);
			check("filter_order_sel word", chan_word, 16'h0A5C);
		end
	endtask : t_filter
	task automatic t_aux();
		wr_reg(5'h00, 8'h00, 8'h00, 1'b0);
		for (int c = 0; c < 4; c++) begin
			wr_reg(5'h01, {c[1:0], 6'h00}, 8'h00, 1'b0);
			aux_pin = 1'b0;
			next_start(n);
			check("fall", n < 1000, c[1]);
			// a set still in flight would drop the next edge
			repeat (6) @(negedge clk);
			aux_pin = 1'b1;
			next_start(n);
			check("rise", n < 1000, c[0]);
		end
	endtask : t_aux
	task automatic t_auto();
		wr_reg(5'h00, 8'hF0, 8'h00, 1'b0);
		next_start(n);
		next_start(n);
		next_start(n);
		check("period", n, 16'd200);
		wr_reg(5'h00, 8'h00, 8'h00, 1'b0);
		next_start(n);
		check("manual", n, 16'd1000);
	endtask : t_auto
	////////////////////////////////////////
	initial begin
		srst = 1'b1;
		aux_pin = 1'b1;
		host_conv_req = 1'b0;
		irq_clear = 1'b0;
		pen_detected = 1'b0;
		adc_done = 1'b0;
		repeat (20) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		t_regs();
		t_decode();
		t_conv();
		t_filter();
		t_aux();
		t_auto();
		close_out();
	end
	// whole run is near 21k cycles
	initial begin
		#1000000;
		bad_count++;
		close_out();
	end
endmodule : tcc_conv_ctrl_tb

// [test/tcc_conv_monitor.sv]
`timescale 1ns/1ns
module tcc_conv_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// watched ports
	input wire logic irq_clear,
	input wire logic sda_out,
	input wire logic bias_en,
	input wire logic adc_start,
	input wire logic irq_out_n,
	input wire logic [15:0] chan_word,
	input wire logic data_invalid,
	input wire logic result_valid,
	input wire logic [7:0] pen_res_kohm,
	input wire logic [2:0] filter_order_sel_samples,
	input wire logic filter_order_sel_median
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	////////////////////////////////////////
	sequence s_one_shot;
		result_valid ##1 !result_valid;
	endsequence
	property p_settle;
		adc_start |-> bias_en && $past(bias_en);
	endproperty
	property p_start_pulse;
		adc_start |=> !adc_start;
	endproperty
	property p_invalid_word;
		result_valid && data_invalid |-> chan_word == 16'hFFFF;
	endproperty
	property p_valid_word;
		result_valid && !data_invalid |-> chan_word[15:12] == 4'h0;
	endproperty
	property p_valid_pulse;
		result_valid |-> s_one_shot;
	endproperty
	property p_irq_at_end;
		$fell(irq_out_n) |-> (##[0:1] result_valid) or $past(result_valid);
	endproperty
	property p_irq_hold;
		!irq_out_n && !irq_clear |=> !irq_out_n;
	endproperty
	property p_res;
		pen_res_kohm inside {8'h64, 8'hC8, 8'h32, 8'h19};
	endproperty
	property p_filter_order_sel;
		filter_order_sel_samples inside {3'h1, 3'h3, 3'h5, 3'h7};
	endproperty
	property p_median;
		filter_order_sel_median == (filter_order_sel_samples == 3'h7);
	endproperty
	property p_odrain;
		sda_out == 1'b0;
	endproperty
	a_settle: assert property (p_settle) else $error("start without settle");
	a_start_pulse: assert property (p_start_pulse) else $error("start too long");
	a_invalid_word: assert property (p_invalid_word) else $error("invalid word");
	a_valid_word: assert property (p_valid_word) else $error("valid word top");
	a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
	a_irq_at_end: assert property (p_irq_at_end) else $error("irq off end");
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
	a_res: assert property (p_res) else $error("bad resistor");
	a_filter_order_sel: assert property (p_filter_order_sel) else $error("bad samples");
	a_median: assert property (p_median) else $error("bad median");
	a_odrain: assert property (p_odrain) else $error("sda driven high");
endmodule : tcc_conv_monitor
bind tcc_conv_ctrl tcc_conv_monitor tcc_conv_monitor_inst (.clk(clk), .srst(srst),
	.irq_clear(irq_clear), .sda_out(sda_out), .bias_en(bias_en), .adc_start(adc_start),
	.irq_out_n(irq_out_n), .chan_word(chan_word), .data_invalid(data_invalid),
	.result_valid(result_valid), .pen_res_kohm(pen_res_kohm), .filter_order_sel_samples(filter_order_sel_samples),
	.filter_order_sel_median(filter_order_sel_median));

// [test/tcc_host_model.sv]
`timescale 1ns/1ns
module tcc_host_model (
	// clock
	input wire logic clk,
	// i2c wire level
	input wire logic sda_in,
	output logic scl,
	output logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	////////////////////////////////////////
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask : hold
	// also serves as repeated start: sda falls while scl is high
	task automatic start();
		sda_low = 1'b0;
		hold(4);
		scl = 1'b1;
		hold(8);
		sda_low = 1'b1;
		hold(8);
		scl = 1'b0;
		hold(4);
	endtask : start
	task automatic stop();
		sda_low = 1'b1;
		hold(4);
		scl = 1'b1;
		hold(8);
		sda_low = 1'b0;
		hold(8);
	endtask : stop
	// data only moves while scl is low, sampled mid high
	task automatic bit_io(input logic b, output logic s);
		sda_low = !b;
		hold(4);
		scl = 1'b1;
		hold(4);
		s = sda_in;
		hold(4);
		scl = 1'b0;
		hold(4);
	endtask : bit_io
	// msb first, ninth bit is the acknowledge slot
	task automatic xfer(input logic [7:0] wb, input logic mack, output logic [7:0] rb,
		output logic ack_n);
		for (int i = 7; i >= 0; i--) begin
			bit_io(wb[i], rb[i]);
		end
		bit_io(mack, ack_n);
	endtask : xfer
endmodule : tcc_host_model
